// [verilog/ofd_decoder.sv]
// What this block does
// - a=0 selects access RAM, bank ignored
// - a=1 forms address from bank and file
// - Three-bit field picks bit zero to seven
// - d=0 writes accumulator, d=1 writes file
// - Short file field is 8-bit address
// - Move source: 12-bit address, first word
// - Move destination: 12-bit address, second word
// - Literals are 8, 12 or 20 bits
// - Table pointer: keep, post-inc, post-dec, pre-inc
// - Relative branch signed; call/goto absolute target
// - Fast bit saves/restores shadows, else untouched
// - 21-bit table pointer and 8-bit latch
// - Five arithmetic flags updated by results
// - Product kept as high and low byte
// - Lone second word executes as no-operation
// - Cycle is four clocks; double words two
`timescale 1ns/1ps
module ofd_decoder #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Instruction fetch path
	input wire logic word_valid,
	input wire logic [15:0] word_in,
	input wire ofd_pkg::ofd_fmt_type fmt_in,
	input wire logic [20:0] pc_in,
	output logic word_ready,
	// Execution datapath
	output ofd_pkg::ofd_fields_type fields,
	output logic ops_valid,
	input wire logic result_valid,
	input wire logic [7:0] result,
	input wire logic [4:0] flag_we,
	input wire logic [4:0] flag_val,
	input wire logic mul_valid,
	input wire logic [15:0] mul_product,
	input wire logic tbl_rd_valid,
	input wire logic [7:0] tbl_rd_byte,
	output logic [7:0] working_accumulator,
	output logic [3:0] bank_select_register,
	output logic [20:0] table_pointer,
	output logic [7:0] table_latch,
	output logic [4:0] status_flags,
	output logic [7:0] product_high_byte,
	output logic [7:0] product_low_byte,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

	if (ADDR_W < 5 || ADDR_W > 8) begin : g_addr_check
		$error("ADDR_W must lie between 5 and 8");
	end

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [11:0] access_map(input logic [7:0] f);
		return (f < ofd_pkg::ACCESS_SPLIT) ?
			{ofd_pkg::ACCESS_LOW_BANK, f} : {ofd_pkg::ACCESS_HIGH_BANK, f};
	endfunction

	function automatic logic [20:0] rel_target(input logic [20:0] pc,
		input logic [20:0] off);
		return pc + ofd_pkg::PC_STEP + {off[19:0], 1'b0};
	endfunction

	function automatic logic [7:0] lane_merge(input logic [7:0] old,
		input logic [7:0] nw, input logic en);
		return en ? nw : old;
	endfunction

	// ****************************************************************
	// Instruction cycle timing
	// ****************************************************************
	logic [1:0] quarter_r;
	logic word_ready_r;
	logic pend_r;
	logic [15:0] pend_word_r;
	ofd_pkg::ofd_fmt_type pend_fmt_r;
	ofd_pkg::ofd_fields_type fields_r;
	logic ops_valid_r;
	wire take_w = word_valid && word_ready_r;
	// A word is only taken at the last quarter, so each cycle is 4 clocks
	always_ff @(posedge mclk) begin
		if (reset) begin
			quarter_r <= 2'h0;
			word_ready_r <= 1'b0;
		end else begin
			quarter_r <= quarter_r + 2'h1;
			word_ready_r <= (quarter_r == ofd_pkg::QUARTER_READY);
		end
	end

	// ****************************************************************
	// Operand decode
	// ****************************************************************
	logic [3:0] bank_r;
	logic [20:0] tptr_r;
	wire first_two_w = (fmt_in == ofd_pkg::FMT_MOVFF) ||
		(fmt_in == ofd_pkg::FMT_GOTO) || (fmt_in == ofd_pkg::FMT_CALL) ||
		(fmt_in == ofd_pkg::FMT_LIT12);
	// A stray second word, or a broken pair, falls through as no-operation
	wire pair_ok_w = pend_r && (word_in[15:12] == ofd_pkg::SECOND_MARK);
	wire lone_second_w = !pend_r && (fmt_in == ofd_pkg::FMT_SECOND);
	ofd_pkg::ofd_fmt_type eff_fmt_w;
	assign eff_fmt_w = pend_r ? pend_fmt_r : fmt_in;
	wire [15:0] w1_w = pend_r ? pend_word_r : word_in;
	wire [15:0] w2_w = word_in;
	wire [7:0] f8_w = w1_w[7:0];
	wire abit_w = w1_w[8];
	wire [1:0] tm_w = w1_w[1:0];
	wire [20:0] tbl_inc_w = tptr_r + 21'h000001;
	wire [20:0] tbl_dec_w = tptr_r - 21'h000001;
	wire [20:0] bra_off_w = {{10{w1_w[10]}}, w1_w[10:0]};
	wire [20:0] bc_off_w = {{13{w1_w[7]}}, w1_w[7:0]};
	ofd_pkg::ofd_fields_type dec_w;

	always_comb begin
		dec_w = '0;
		dec_w.fmt = eff_fmt_w;
		dec_w.nop = lone_second_w || (pend_r && !pair_ok_w) ||
			(eff_fmt_w == ofd_pkg::FMT_NONE);
		dec_w.file8 = f8_w;
		dec_w.bank_sel = abit_w;
		dec_w.ram_addr = abit_w ? {bank_r, f8_w} : access_map(f8_w);
		dec_w.dest_file = w1_w[9];
		dec_w.bit_num = w1_w[11:9];
		dec_w.bit_sel = 8'h01 << w1_w[11:9];
		dec_w.source_file_field = w1_w[11:0];
		dec_w.destination_file_field = w2_w[11:0];
		dec_w.lit_width = ofd_pkg::LIT_W8;
		dec_w.literal = {12'h000, w1_w[7:0]};
		dec_w.fast = 1'b0;
		dec_w.table_pointer_mode = ofd_pkg::ofd_tblmode_type'(tm_w);
		dec_w.tbl_addr = tptr_r;
		unique case (eff_fmt_w)
			ofd_pkg::FMT_LIT12: begin
				dec_w.lit_width = ofd_pkg::LIT_W12;
				dec_w.literal = {8'h00, w1_w[3:0], w2_w[7:0]};
			end
			ofd_pkg::FMT_GOTO, ofd_pkg::FMT_CALL: begin
				dec_w.lit_width = ofd_pkg::LIT_W20;
				dec_w.literal = {w2_w[11:0], w1_w[7:0]};
				dec_w.branch_abs = 1'b1;
				dec_w.branch_target = {w2_w[11:0], w1_w[7:0], 1'b0};
				dec_w.fast = (eff_fmt_w == ofd_pkg::FMT_CALL) && w1_w[8];
			end
			ofd_pkg::FMT_BRA:
				dec_w.branch_target = rel_target(pc_in, bra_off_w);
			ofd_pkg::FMT_BCOND:
				dec_w.branch_target = rel_target(pc_in, bc_off_w);
			ofd_pkg::FMT_RETURN:
				dec_w.fast = w1_w[0];
			ofd_pkg::FMT_TABLE:
				if (tm_w == 2'(ofd_pkg::TBL_PRE_INC)) begin
					dec_w.tbl_addr = tbl_inc_w;
				end
			default: ;
		endcase
	end

	// Unused fields keep whatever bits the word held: don't-care positions
	// never cause a refusal.
	wire exec_w = take_w && !(!pend_r && first_two_w);
	always_ff @(posedge mclk) begin
		if (reset) begin
			pend_r <= 1'b0;
			pend_word_r <= 16'h0000;
			pend_fmt_r <= ofd_pkg::FMT_NONE;
			fields_r <= '0;
			ops_valid_r <= 1'b0;
		end else if (quarter_r == ofd_pkg::QUARTER_LAST) begin
			// A first word waits for its partner through empty slots
			if (take_w)
				pend_r <= !pend_r && first_two_w;
			if (take_w && !pend_r) begin
				pend_word_r <= word_in;
				pend_fmt_r <= fmt_in;
			end
			if (exec_w) begin
				fields_r <= dec_w;
			end
			ops_valid_r <= exec_w && !dec_w.nop;
		end
	end

	// ****************************************************************
	// Core registers
	// ****************************************************************
	logic [7:0] accum_r;
	logic [7:0] tbllat_r;
	logic [4:0] flags_r;
	logic [15:0] prod_r;
	ofd_pkg::ofd_shadow_type shadow_r;
	wire [ADDR_W-1:0] aw_w;
	wire wr_go_w;
	wire [7:0] woff_w = 8'(aw_w);
	wire [31:0] wd_w;
	wire [3:0] ws_w;
	// Core flag updates win bit by bit over a bus write in the same cycle
	wire wr_flags_w = wr_go_w && woff_w == ofd_pkg::OFF_FLAGS && ws_w[0];
	wire [4:0] flags_base_w = wr_flags_w ? wd_w[4:0] : flags_r;
	wire exec_tbl_w = exec_w && (eff_fmt_w == ofd_pkg::FMT_TABLE);
	wire save_w = exec_w && dec_w.fast && (eff_fmt_w == ofd_pkg::FMT_CALL);
	wire restore_w = exec_w && dec_w.fast &&
		(eff_fmt_w == ofd_pkg::FMT_RETURN);

	always_ff @(posedge mclk) begin
		if (reset) begin
			bank_r <= ofd_pkg::BANK_RST;
			accum_r <= ofd_pkg::BYTE_RST;
			tptr_r <= ofd_pkg::TPTR_RST;
			tbllat_r <= ofd_pkg::BYTE_RST;
			flags_r <= ofd_pkg::FLAGS_RST;
			prod_r <= {ofd_pkg::BYTE_RST, ofd_pkg::BYTE_RST};
			shadow_r <= '0;
		end else begin
			// Bus writes first, so core activity in the same cycle wins
			if (wr_go_w && woff_w == ofd_pkg::OFF_BANK && ws_w[0])
				bank_r <= wd_w[3:0];
			if (wr_go_w && woff_w == ofd_pkg::OFF_ACCUM)
				accum_r <= lane_merge(accum_r, wd_w[7:0], ws_w[0]);
			if (wr_go_w && woff_w == ofd_pkg::OFF_TPTR)
				tptr_r <= {ws_w[2] ? wd_w[20:16] : tptr_r[20:16],
					lane_merge(tptr_r[15:8], wd_w[15:8], ws_w[1]),
					lane_merge(tptr_r[7:0], wd_w[7:0], ws_w[0])};
			if (wr_go_w && woff_w == ofd_pkg::OFF_TBLLAT)
				tbllat_r <= lane_merge(tbllat_r, wd_w[7:0], ws_w[0]);
			if (result_valid && !fields_r.dest_file)
				accum_r <= result;
			flags_r <= (flags_base_w & ~flag_we) | (flag_val & flag_we);
			if (mul_valid)
				prod_r <= mul_product;
			if (tbl_rd_valid)
				tbllat_r <= tbl_rd_byte;
			if (exec_tbl_w) begin
				unique case (dec_w.table_pointer_mode)
					ofd_pkg::TBL_KEEP: ;
					ofd_pkg::TBL_POST_INC, ofd_pkg::TBL_PRE_INC:
						tptr_r <= tbl_inc_w;
					ofd_pkg::TBL_POST_DEC: tptr_r <= tbl_dec_w;
				endcase
			end
			if (save_w)
				shadow_r <= '{accum: accum_r, flags: flags_r, bank: bank_r};
			if (restore_w) begin
				accum_r <= shadow_r.accum;
				flags_r <= shadow_r.flags;
				bank_r <= shadow_r.bank;
			end
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic awready_r, wready_r, arready_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r, rdata_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;
	wire aw_hs_w = s_axi_awvalid && awready_r;
	wire w_hs_w = s_axi_wvalid && wready_r;
	assign aw_w = awaddr_r;
	assign wd_w = wdata_r;
	assign ws_w = wstrb_r;
	assign wr_go_w = aw_got_r && w_got_r && !bvalid_r;
	wire wr_map_w = (woff_w <= ofd_pkg::OFF_FLAGS) && (woff_w[1:0] == 2'h0);
	wire [7:0] roff_w = 8'(s_axi_araddr);
	wire ar_hs_w = s_axi_arvalid && arready_r;
	logic [31:0] rmux_w;
	logic rmap_w;
	always_comb begin
		rmap_w = 1'b1;
		unique case (roff_w)
			ofd_pkg::OFF_BANK: rmux_w = {28'h0000000, bank_r};
			ofd_pkg::OFF_ACCUM: rmux_w = {24'h000000, accum_r};
			ofd_pkg::OFF_TPTR: rmux_w = {11'h000, tptr_r};
			ofd_pkg::OFF_TBLLAT: rmux_w = {24'h000000, tbllat_r};
			ofd_pkg::OFF_FLAGS: rmux_w = {27'h0000000, flags_r};
			ofd_pkg::OFF_PROD: rmux_w = {16'h0000, prod_r};
			ofd_pkg::OFF_STATE: rmux_w = {26'h0000000, pend_r, ops_valid_r,
				fields_r.fmt};
			default: begin
				rmux_w = 32'h00000000;
				rmap_w = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= ofd_pkg::RESP_OKAY;
			awaddr_r <= '0;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= ofd_pkg::RESP_OKAY;
		end else begin
			if (aw_hs_w) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_hs_w) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go_w) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_map_w ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			if (ar_hs_w) begin
				rvalid_r <= 1'b1;
				rdata_r <= rmux_w;
				rresp_r <= rmap_w ? ofd_pkg::RESP_OKAY : ofd_pkg::RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// Ready flags sit in flip-flops of their own: each drops as its item
	// is taken and comes back once the answer has been accepted
	always_ff @(posedge mclk) begin
		if (reset) begin
			awready_r <= 1'b1;
			wready_r <= 1'b1;
			arready_r <= 1'b1;
		end else begin
			if (aw_hs_w)
				awready_r <= 1'b0;
			else if (bvalid_r && s_axi_bready)
				awready_r <= 1'b1;
			if (w_hs_w)
				wready_r <= 1'b0;
			else if (bvalid_r && s_axi_bready)
				wready_r <= 1'b1;
			if (ar_hs_w)
				arready_r <= 1'b0;
			else if (rvalid_r && s_axi_rready)
				arready_r <= 1'b1;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_arready = arready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign word_ready = word_ready_r;
	assign fields = fields_r;
	assign ops_valid = ops_valid_r;
	assign working_accumulator = accum_r;
	assign bank_select_register = bank_r;
	assign table_pointer = tptr_r;
	assign table_latch = tbllat_r;
	assign status_flags = flags_r;
	assign product_high_byte = prod_r[15:8];
	assign product_low_byte = prod_r[7:0];

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	wire take_last_w = take_w && quarter_r == ofd_pkg::QUARTER_LAST;
	sequence s_first_word;
		take_last_w && !pend_r && first_two_w;
	endsequence
	sequence s_fast_call;
		take_last_w && save_w;
	endsequence

	access_map_a: assert property (ops_valid_r && !fields_r.bank_sel &&
		(fields_r.fmt == ofd_pkg::FMT_BYTE) |->
		fields_r.ram_addr == access_map(fields_r.file8))
		else $error("access RAM address wrong");
	bank_addr_a: assert property (take_last_w && exec_w && abit_w |=>
		fields_r.ram_addr == {$past(bank_r), $past(f8_w)})
		else $error("banked address wrong");
	bit_select_a: assert property (ops_valid_r |->
		fields_r.bit_sel == 8'(8'h01 << fields_r.bit_num))
		else $error("bit select mismatch");
	cycle_four_a: assert property (take_w |=> !take_w [*3])
		else $error("word taken inside a cycle");
	dword_wait_a: assert property (s_first_word |=> !ops_valid_r [*4])
		else $error("double word executed early");
	lone_nop_a: assert property (take_w && lone_second_w |=> !ops_valid_r)
		else $error("lone second word executed");
	preinc_addr_a: assert property (take_w && exec_tbl_w &&
		tm_w == 2'(ofd_pkg::TBL_PRE_INC) |=>
		fields_r.tbl_addr == $past(tptr_r) + 21'h000001)
		else $error("pre-increment address wrong");
	fast_save_a: assert property (s_fast_call |=>
		shadow_r.bank == $past(bank_r))
		else $error("shadow not loaded");
	resp_hold_a: assert property (bvalid_r && !s_axi_bready |=> bvalid_r)
		else $error("write response dropped");
	ready_state_a: assert property (awready_r ==
		(!aw_got_r && !bvalid_r))
		else $error("address ready out of step");

endmodule // ofd_decoder

// [verilog/ofd_pkg.sv]
package ofd_pkg;

	// ****************************************************************
	// Register map (byte offsets, 32-bit words)
	// ****************************************************************
	localparam logic [7:0] OFF_BANK = 8'h00;
	localparam logic [7:0] OFF_ACCUM = 8'h04;
	localparam logic [7:0] OFF_TPTR = 8'h08;
	localparam logic [7:0] OFF_TBLLAT = 8'h0C;
	localparam logic [7:0] OFF_FLAGS = 8'h10;
	localparam logic [7:0] OFF_PROD = 8'h14;
	localparam logic [7:0] OFF_STATE = 8'h18;

	// ****************************************************************
	// Reset values, widths and fixed codes
	// ****************************************************************
	localparam logic [3:0] BANK_RST = 4'h0;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [20:0] TPTR_RST = 21'h000000;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam logic [1:0] QUARTER_LAST = 2'h3;
	localparam logic [1:0] QUARTER_READY = 2'h2;
	localparam logic [3:0] SECOND_MARK = 4'hF;
	localparam logic [7:0] ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
	localparam logic [20:0] PC_STEP = 21'h000002;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Flag bit positions in the status word
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [3:0] {
		FMT_NONE, FMT_BYTE, FMT_BIT, FMT_LIT8, FMT_LIT12, FMT_MOVFF,
		FMT_GOTO, FMT_CALL, FMT_BRA, FMT_BCOND, FMT_TABLE, FMT_RETURN,
		FMT_SECOND
	} ofd_fmt_type;

	typedef enum logic [1:0] {
		TBL_KEEP, TBL_POST_INC, TBL_POST_DEC, TBL_PRE_INC
	} ofd_tblmode_type;

	typedef enum logic [1:0] {
		LIT_W8, LIT_W12, LIT_W20
	} ofd_litw_type;

	typedef struct packed {
		ofd_fmt_type fmt;
		logic nop;
		logic bank_sel;
		logic [11:0] ram_addr;
		logic [7:0] file8;
		logic dest_file;
		logic [2:0] bit_num;
		logic [7:0] bit_sel;
		logic [11:0] source_file_field;
		logic [11:0] destination_file_field;
		logic [19:0] literal;
		ofd_litw_type lit_width;
		logic branch_abs;
		logic [20:0] branch_target;
		logic fast;
		ofd_tblmode_type table_pointer_mode;
		logic [20:0] tbl_addr;
	} ofd_fields_type;

	typedef struct packed {
		logic [7:0] accum;
		logic [4:0] flags;
		logic [3:0] bank;
	} ofd_shadow_type;

endpackage

// [verification/ofd_fetch_model.sv]
`timescale 1ns/1ps
module ofd_fetch_model (
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Fetch handshake
	input wire logic word_ready,
	input wire logic [3:0] gap_len,
	output logic word_valid,
	output logic [15:0] word_in,
	output ofd_pkg::ofd_fmt_type fmt_in,
	output logic [20:0] pc_in,
	output logic busy
);
	logic [40:0] q[$];
	int gap = 0;

	initial begin
		word_valid = 1'b0;
		word_in = 16'h0000;
		fmt_in = ofd_pkg::FMT_NONE;
		pc_in = 21'h000000;
		busy = 1'b0;
	end

	// Callers build words with zero in every don't-care bit, except the lone second word, which carries 555 there
	task automatic push(input logic [15:0] w, input ofd_pkg::ofd_fmt_type f,
		input logic [20:0] pc);
		q.push_back({w, f, pc});
	endtask

	// Offer held until taken; idle lines toggle so no stale word is seen
	always @(posedge mclk) begin
		logic nv;
		logic [40:0] c;
		if (word_valid && word_ready)
			gap = gap_len;
		nv = word_valid && !word_ready && !reset;
		if (!nv && !reset && gap > 0)
			gap--;
		else if (!nv && !reset && q.size() != 0) begin
			c = q.pop_front();
			nv = 1'b1;
			word_in <= c[40:25];
			fmt_in <= ofd_pkg::ofd_fmt_type'(c[24:21]);
			pc_in <= c[20:0];
		end
		if (!nv) begin
			word_in <= ~word_in;
			pc_in <= ~pc_in;
		end
		word_valid <= nv;
		busy <= nv || q.size() != 0;
	end
endmodule // ofd_fetch_model

// [verification/tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
	$display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic word_valid, word_ready, ops_valid, busy;
	logic [15:0] word_in;
	ofd_pkg::ofd_fmt_type fmt_in;
	logic [20:0] pc_in, tptr;
	ofd_pkg::ofd_fields_type fields;
	logic rv = 1'b0, mv = 1'b0, tv = 1'b0;
	logic [7:0] res = 8'h00, tbyte = 8'h00, acc, lat, ph, pl;
	logic [4:0] fwe = 5'h00, fval = 5'h00, flags;
	logic [15:0] prod = 16'h0000;
	logic [3:0] bank, gap_len = 4'h0;
	logic [3:0] wstrb = 4'hF;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [1:0] bresp, rresp;
	int errors = 0;
	int n_checks = 0;

	always #50 mclk = ~mclk;

	ofd_decoder dut (.mclk(mclk), .reset(reset), .word_valid(word_valid),
		.word_in(word_in), .fmt_in(fmt_in), .pc_in(pc_in),
		.word_ready(word_ready), .fields(fields), .ops_valid(ops_valid),
		.result_valid(rv), .result(res), .flag_we(fwe), .flag_val(fval),
		.mul_valid(mv), .mul_product(prod), .tbl_rd_valid(tv),
		.tbl_rd_byte(tbyte), .working_accumulator(acc),
		.bank_select_register(bank), .table_pointer(tptr),
		.table_latch(lat), .status_flags(flags), .product_high_byte(ph),
		.product_low_byte(pl), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	ofd_fetch_model fetch (.mclk(mclk), .reset(reset),
		.word_ready(word_ready), .gap_len(gap_len),
		.word_valid(word_valid), .word_in(word_in), .fmt_in(fmt_in),
		.pc_in(pc_in), .busy(busy));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic hang();
		errors++;
		$display("Error %0t: wait ran out", $time);
		complete_run();
	endtask

	// Handshake flags are sampled at the falling edge, where they are settled
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r, input logic [3:0] s = 4'hF);
		logic ah, wh, bh;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge mclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge mclk);
			if (ah)
				awvalid <= 1'b0;
			if (wh)
				wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic ah, dh;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(negedge mclk);
			ah = arvalid && arready;
			dh = rvalid;
			if (dh) begin
				`CHK(rdata, e)
				`CHK(rresp, er)
			end
			@(posedge mclk);
			if (ah)
				arvalid <= 1'b0;
			if (dh) begin
				rready <= 1'b0;
				return;
			end
		end
		hang();
	endtask

	// Returns at the falling edge after the last queued word is taken
	task automatic exec();
		@(posedge mclk);
		for (int i = 0; i < 80; i++) begin
			@(negedge mclk);
			if (!busy)
				return;
		end
		hang();
	endtask

	task automatic issue(input logic [15:0] w, input ofd_pkg::ofd_fmt_type f);
		fetch.push(w, f, 21'h000100);
		exec();
	endtask

	task automatic pair(input logic [15:0] w1, input ofd_pkg::ofd_fmt_type f,
		input logic [15:0] w2);
		fetch.push(w1, f, 21'h000100);
		fetch.push(w2, ofd_pkg::FMT_SECOND, 21'h000100);
		exec();
	endtask

	task automatic dp(input logic [7:0] r, input logic [4:0] we,
		input logic [4:0] v);
		@(posedge mclk);
		rv <= 1'b1;
		res <= r;
		fwe <= we;
		fval <= v;
		mv <= 1'b1;
		prod <= 16'hBEEF;
		tv <= 1'b1;
		tbyte <= 8'hA5;
		@(posedge mclk);
		rv <= 1'b0;
		mv <= 1'b0;
		tv <= 1'b0;
		fwe <= 5'h00;
		@(negedge mclk);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_regs();
		logic [1:0] r;
		int cnt = 0;
		for (int i = 0; i < 16; i++) begin
			@(negedge mclk);
			cnt += int'(word_ready === 1'b1);
		end
		`CHK(cnt, 4)
		for (int a = 0; a < 28; a += 4)
			rd(8'(a), 32'h00000000, ofd_pkg::RESP_OKAY);
		rd(8'h1C, 32'h00000000, ofd_pkg::RESP_SLVERR);
		axw(ofd_pkg::OFF_TPTR, 32'hFFFFFFFF, r);
		rd(ofd_pkg::OFF_TPTR, 32'h001FFFFF, ofd_pkg::RESP_OKAY);
		`CHK(tptr, 21'h1FFFFF)
		axw(ofd_pkg::OFF_TPTR, 32'h00000000, r, 4'h1);
		`CHK(tptr, 21'h1FFF00)
		axw(ofd_pkg::OFF_FLAGS, 32'h0000000A, r);
		`CHK(flags, 5'h0A)
		axw(ofd_pkg::OFF_FLAGS, 32'h00000000, r);
		axw(ofd_pkg::OFF_TBLLAT, 32'h000001FF, r);
		rd(ofd_pkg::OFF_TBLLAT, 32'h000000FF, ofd_pkg::RESP_OKAY);
		axw(ofd_pkg::OFF_PROD, 32'h00001234, r);
		`CHK(r, ofd_pkg::RESP_SLVERR)
		rd(ofd_pkg::OFF_PROD, 32'h00000000, ofd_pkg::RESP_OKAY);
		$display("register test done");
	endtask

	task automatic t_byte_bit();
		logic [1:0] r;
		logic [7:0] f;
		axw(ofd_pkg::OFF_BANK, 32'h00000005, r);
		for (int i = 0; i < 8; i++) begin
			f = i[2] ? 8'h80 : 8'h7F;
			issue({6'h09, i[1], i[0], f}, ofd_pkg::FMT_BYTE);
			`CHK(fields.dest_file, i[1])
			`CHK(fields.file8, f)
			`CHK(fields.ram_addr, {i[0] ? 4'h5 : f[7] ? 4'hF : 4'h0, f})
		end
		for (int b = 0; b < 8; b++) begin
			issue({4'h8, b[2:0], 1'b1, 8'h20}, ofd_pkg::FMT_BIT);
			`CHK(fields.bit_num, b[2:0])
			`CHK(fields.bit_sel, 8'h01 << b)
			`CHK(fields.ram_addr, 12'h520)
		end
		$display("byte and bit test done");
	endtask

	task automatic t_pair();
		// The second word misses one slot, so the first must wait for it
		gap_len = 4'h5;
		pair({4'hC, 12'hABC}, ofd_pkg::FMT_MOVFF, {4'hF, 12'h123});
		for (int i = 0; i < 4; i++) begin
			`CHK(ops_valid, 1'b1)
			`CHK(fields.source_file_field, 12'hABC)
			`CHK(fields.destination_file_field, 12'h123)
			@(negedge mclk);
		end
		`CHK(ops_valid, 1'b0)
		gap_len = 4'h0;
		pair({4'hC, 12'hFFF}, ofd_pkg::FMT_MOVFF, {4'h0, 12'h000});
		`CHK(fields.nop, 1'b1)
		`CHK(ops_valid, 1'b0)
		issue({4'hF, 12'h555}, ofd_pkg::FMT_SECOND);
		`CHK(ops_valid, 1'b0)
		$display("two-word test done");
	endtask

	task automatic t_lit_tbl_br();
		logic [20:0] tp;
		issue({8'h0E, 8'hA7}, ofd_pkg::FMT_LIT8);
		`CHK(fields.literal, 20'h000A7)
		`CHK(fields.lit_width, ofd_pkg::LIT_W8)
		pair({12'hEE0, 4'hC}, ofd_pkg::FMT_LIT12, {8'hF0, 8'h34});
		`CHK(fields.lit_width, ofd_pkg::LIT_W12)
		`CHK(fields.literal, 20'h00C34)
		for (int m = 0; m < 4; m++) begin
			tp = tptr;
			issue({14'h0002, m[1:0]}, ofd_pkg::FMT_TABLE);
			`CHK(fields.table_pointer_mode, ofd_pkg::ofd_tblmode_type'(m))
			`CHK(fields.tbl_addr, 21'(tp + (m == 3)))
			`CHK(tptr, 21'(tp + m[0] - (m == 2)))
		end
		issue({5'h1A, 11'h7FD}, ofd_pkg::FMT_BRA);
		`CHK(fields.branch_target, 21'h0000FC)
		`CHK(fields.branch_abs, 1'b0)
		issue({8'hE2, 8'h10}, ofd_pkg::FMT_BCOND);
		`CHK(fields.branch_target, 21'h000122)
		pair({8'hEF, 8'hDE}, ofd_pkg::FMT_GOTO, {4'hF, 12'hABC});
		`CHK(fields.branch_target, 21'h1579BC)
		`CHK(fields.branch_abs, 1'b1)
		`CHK(fields.lit_width, ofd_pkg::LIT_W20)
		$display("literal, table and branch test done");
	endtask

	task automatic t_fast();
		logic [1:0] r;
		axw(ofd_pkg::OFF_ACCUM, 32'h0000005A, r);
		axw(ofd_pkg::OFF_BANK, 32'h00000003, r);
		pair({7'h76, 1'b1, 8'h00}, ofd_pkg::FMT_CALL, 16'hF000);
		`CHK(fields.fast, 1'b1)
		axw(ofd_pkg::OFF_ACCUM, 32'h00000011, r);
		axw(ofd_pkg::OFF_BANK, 32'h00000007, r);
		issue(16'h0012, ofd_pkg::FMT_RETURN);
		@(negedge mclk);
		`CHK(acc, 8'h11)
		issue(16'h0013, ofd_pkg::FMT_RETURN);
		@(negedge mclk);
		`CHK(acc, 8'h5A)
		`CHK(bank, 4'h3)
		$display("fast call test done");
	endtask

	task automatic t_dp();
		issue({6'h09, 2'b00, 8'h10}, ofd_pkg::FMT_BYTE);
		dp(8'h3C, 5'h15, 5'h1F);
		`CHK(acc, 8'h3C)
		`CHK(flags, 5'h15)
		`CHK({ph, pl}, 16'hBEEF)
		`CHK(lat, 8'hA5)
		issue({6'h09, 2'b10, 8'h10}, ofd_pkg::FMT_BYTE);
		dp(8'h77, 5'h01, 5'h00);
		`CHK(acc, 8'h3C)
		`CHK(flags, 5'h14)
		rd(ofd_pkg::OFF_PROD, 32'h0000BEEF, ofd_pkg::RESP_OKAY);
		rd(ofd_pkg::OFF_FLAGS, 32'h00000014, ofd_pkg::RESP_OKAY);
		$display("datapath test done");
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		reset <= 1'b0;
		t_regs();
		t_byte_bit();
		t_pair();
		t_lit_tbl_br();
		t_fast();
		t_dp();
		complete_run();
	end
endmodule // tb
